// ---- verilog/tirq_consts.svh ----
/*
  Constants of the timer interrupt request logic: register offsets, bit
  positions, reset values, edge-select codes and the shared vector address.
  Assumes an 8-bit register port with 8-bit addresses.
*/
`ifndef TIRQ_CONSTS_SVH
`define TIRQ_CONSTS_SVH

`define TIRQ_ADDR_FLAGS      8'h00
`define TIRQ_ADDR_ENABLE     8'h01
`define TIRQ_ADDR_CONTROL    8'h02
`define TIRQ_ADDR_EDGE       8'h03

`define TIRQ_BIT_PIN_A       0
`define TIRQ_BIT_PIN_B       1
`define TIRQ_BIT_TIMER_A     4
`define TIRQ_BIT_TIMER_B     5
`define TIRQ_BIT_COUNTER_A   6
`define TIRQ_BIT_COUNTER_B   7
`define TIRQ_BIT_GIE         7

`define TIRQ_IMPL_MASK       8'hf3
`define TIRQ_RST_FLAGS       8'h00
`define TIRQ_RST_ENABLE      8'h00
`define TIRQ_RST_GIE         1'b0
`define TIRQ_RST_EDGE        4'ha

`define TIRQ_EDGE_RSVD       2'b00
`define TIRQ_EDGE_RISE       2'b01
`define TIRQ_EDGE_FALL       2'b10
`define TIRQ_EDGE_BOTH       2'b11

`define TIRQ_VECTOR_ADDR     16'h0008

`endif

// ---- verilog/tirq_pkg.sv ----
/*
  Types of the timer interrupt request logic.
  Assumes tirq_consts.svh is on the include path.
*/
`include "tirq_consts.svh"

package tirq_pkg;
  typedef logic [7:0] tirq_byte_t;
  typedef enum logic [1:0] {
    tirq_edge_reserved = `TIRQ_EDGE_RSVD,
    tirq_edge_rising   = `TIRQ_EDGE_RISE,
    tirq_edge_falling  = `TIRQ_EDGE_FALL,
    tirq_edge_both     = `TIRQ_EDGE_BOTH
  } tirq_edge_e;
endpackage : tirq_pkg

// ---- verilog/tirq_flag_if.sv ----
/*
  Interface between the control logic and the pending flag bank.
  Assumes set and clear are one-cycle pulses on the bank's clock.
*/
`timescale 1ns/10ps
`default_nettype none

interface tirq_flag_if #(parameter int N = 8);
  logic [N-1:0] set;
  logic [N-1:0] clear;
  logic [N-1:0] flag;
  modport bank (input set, input clear, output flag);
  modport ctrl (output set, output clear, input flag);
endinterface : tirq_flag_if

`default_nettype wire

// ---- verilog/tirq_flag_bank.sv ----
/*
  Bank of sticky pending flags.
  Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module tirq_flag_bank
  import tirq_pkg::*;
#(
  parameter int           N     = 8,
  parameter logic [N-1:0] RESET = '0
) (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_reset,
  // flag carrier
  tirq_flag_if.bank flags
);

  // a set in the clearing cycle survives
  wire logic [N-1:0] next_flag = (flags.flag & ~flags.clear) | flags.set;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      flags.flag <= RESET;
    end else begin
      flags.flag <= next_flag;
    end
  end

endmodule : tirq_flag_bank

`default_nettype wire

// ---- verilog/tirq_pin_edge.sv ----
/*
  Synchroniser and edge detector for one external interrupt pin.
  Assumes the pin is asynchronous to i_clock.
*/
`timescale 1ns/10ps
`default_nettype none

module tirq_pin_edge
  import tirq_pkg::*;
(
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  // pin and edge choice
  input  wire logic       i_pin,
  input  wire logic [1:0] i_edge_select,
  // detected edge, one cycle
  output logic            o_edge
);

  logic       sync_first;
  logic       sync_second;
  logic       pin_prev;
  logic       next_edge;
  tirq_edge_e edge_mode;

  assign edge_mode = tirq_edge_e'(i_edge_select);

  always_comb begin
    next_edge = 1'b0;
    unique case (edge_mode)
      tirq_edge_reserved: next_edge = 1'b0;
      tirq_edge_rising:   next_edge = sync_second & ~pin_prev;
      tirq_edge_falling:  next_edge = ~sync_second & pin_prev;
      tirq_edge_both:     next_edge = sync_second ^ pin_prev;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      sync_first  <= 1'b0;
      sync_second <= 1'b0;
      pin_prev    <= 1'b0;
      o_edge      <= 1'b0;
    end else begin
      sync_first  <= i_pin;
      sync_second <= sync_first;
      pin_prev    <= sync_second;
      o_edge      <= next_edge;
    end
  end

endmodule : tirq_pin_edge

`default_nettype wire

// ---- verilog/tirq_request.sv ----
/*
  Timer interrupt request logic: pending flags for two timers, two
  timer/counters and two external pins, enable bits, a global enable and
  the request toward the core's single shared vector.
  Assumes overflow pulses come from timer logic on i_clock and the core
  answers a request with a one-cycle accept on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tirq_consts.svh"

// Functional notes
// - First timer overflow sets its flag always; request needs its enable.
// - Second timer overflow sets its flag always; request needs its enable.
// - First counter overflow sets flag even disabled; request needs enable and flag.
// - Second counter overflow sets flag regardless; request needs enable and flag.
// - Flags set only by own events; a flag alone never requests entry.
// - Pin flags set on the edge currently chosen for each pin.
// - No request without global enable, which resets to zero.
// - Accepted request loads vector address 8 and pushes one return level.
// - Edge code 00 reserved, 01 rising, 10 falling, 11 both.
module tirq_request
  import tirq_pkg::*;
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  // register port
  input  wire logic [7:0]  i_address,
  input  wire logic [7:0]  i_write_data,
  input  wire logic        i_write_strobe,
  input  wire logic        i_read_strobe,
  output logic      [7:0]  o_read_data,
  // overflow events from the timers
  input  wire logic        i_timer_a_overflow,
  input  wire logic        i_timer_b_overflow,
  input  wire logic        i_counter_a_overflow,
  input  wire logic        i_counter_b_overflow,
  // external interrupt pins
  input  wire logic        i_pin_a,
  input  wire logic        i_pin_b,
  // core side
  input  wire logic        i_irq_accept,
  output logic             o_irq_request,
  output logic             o_vector_load,
  output logic             o_stack_push,
  output logic      [15:0] o_vector_address
);

  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] reg_addr);
    addr_is = (addr == reg_addr);
  endfunction : addr_is

  tirq_flag_if #(.N(8)) fl ();

  tirq_byte_t irq_enable;
  logic       global_irq_enable;
  logic [3:0] pin_edge_select;

  logic pin_a_edge;
  logic pin_b_edge;

  wire logic write_flags   = i_write_strobe && addr_is(i_address, `TIRQ_ADDR_FLAGS);
  wire logic write_enable  = i_write_strobe && addr_is(i_address, `TIRQ_ADDR_ENABLE);
  wire logic write_control = i_write_strobe && addr_is(i_address, `TIRQ_ADDR_CONTROL);
  wire logic write_edge    = i_write_strobe && addr_is(i_address, `TIRQ_ADDR_EDGE);

  wire logic timer_a_pending_flag   = fl.flag[`TIRQ_BIT_TIMER_A];
  wire logic timer_b_pending_flag   = fl.flag[`TIRQ_BIT_TIMER_B];
  wire logic counter_a_pending_flag = fl.flag[`TIRQ_BIT_COUNTER_A];
  wire logic counter_b_pending_flag = fl.flag[`TIRQ_BIT_COUNTER_B];
  wire logic pin_a_pending_flag     = fl.flag[`TIRQ_BIT_PIN_A];
  wire logic pin_b_pending_flag     = fl.flag[`TIRQ_BIT_PIN_B];

  wire logic timer_a_irq_enable     = irq_enable[`TIRQ_BIT_TIMER_A];
  wire logic timer_b_irq_enable     = irq_enable[`TIRQ_BIT_TIMER_B];
  wire logic counter_a_irq_enable   = irq_enable[`TIRQ_BIT_COUNTER_A];
  wire logic counter_b_irq_enable   = irq_enable[`TIRQ_BIT_COUNTER_B];

  // each bit fed by its own event only
  wire tirq_byte_t flag_set = {
    i_counter_b_overflow, i_counter_a_overflow,
    i_timer_b_overflow,   i_timer_a_overflow,
    2'b00,
    pin_b_edge,           pin_a_edge
  };
  assign fl.set = flag_set;

  // writing zero clears, writing one keeps
  assign fl.clear = write_flags ? ~i_write_data : 8'h00;

  wire tirq_byte_t armed_sources = irq_enable & fl.flag;
  wire logic       next_request  = global_irq_enable && (|armed_sources);

  // entry only when a live request is accepted
  wire logic accept_hit = i_irq_accept && o_irq_request;

  wire tirq_byte_t read_mux =
      addr_is(i_address, `TIRQ_ADDR_FLAGS)   ? fl.flag :
      addr_is(i_address, `TIRQ_ADDR_ENABLE)  ? irq_enable :
      addr_is(i_address, `TIRQ_ADDR_CONTROL) ? {global_irq_enable, 7'h00} :
      addr_is(i_address, `TIRQ_ADDR_EDGE)    ? {4'h0, pin_edge_select} :
      8'h00;
  wire tirq_byte_t next_read_data = i_read_strobe ? read_mux : 8'h00;

  tirq_flag_bank #(
    .N     (8),
    .RESET (`TIRQ_RST_FLAGS)
  ) u_flags (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .flags   (fl.bank)
  );

  tirq_pin_edge u_pin_a (
    .i_clock       (i_clock),
    .i_reset       (i_reset),
    .i_pin         (i_pin_a),
    .i_edge_select (pin_edge_select[1:0]),
    .o_edge        (pin_a_edge)
  );

  tirq_pin_edge u_pin_b (
    .i_clock       (i_clock),
    .i_reset       (i_reset),
    .i_pin         (i_pin_b),
    .i_edge_select (pin_edge_select[3:2]),
    .o_edge        (pin_b_edge)
  );

  // unimplemented enable bits stay zero so they can never arm a request
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      irq_enable <= `TIRQ_RST_ENABLE;
    end else if (write_enable) begin
      irq_enable <= i_write_data & `TIRQ_IMPL_MASK;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      global_irq_enable <= `TIRQ_RST_GIE;
    end else if (write_control) begin
      global_irq_enable <= i_write_data[`TIRQ_BIT_GIE];
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      pin_edge_select <= `TIRQ_RST_EDGE;
    end else if (write_edge) begin
      pin_edge_select <= i_write_data[3:0];
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_read_data <= 8'h00;
    end else begin
      o_read_data <= next_read_data;
    end
  end

  // request is a level; the core keeps it from re-entering by its own gating
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_irq_request <= 1'b0;
    end else begin
      o_irq_request <= next_request;
    end
  end

  // vector load with one stack push
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_vector_load    <= 1'b0;
      o_stack_push     <= 1'b0;
      o_vector_address <= `TIRQ_VECTOR_ADDR;
    end else begin
      o_vector_load    <= accept_hit;
      o_stack_push     <= accept_hit;
      o_vector_address <= `TIRQ_VECTOR_ADDR;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  property p_timer_a_set;
    i_timer_a_overflow |=> timer_a_pending_flag;
  endproperty
  a_timer_a_set: assert property (p_timer_a_set)
    else $error("timer a overflow did not set its flag");

  property p_timer_b_set;
    (i_timer_b_overflow && !timer_b_irq_enable) |=> timer_b_pending_flag;
  endproperty
  a_timer_b_set: assert property (p_timer_b_set)
    else $error("timer b overflow with enable low did not set its flag");

  property p_counter_a_set;
    (i_counter_a_overflow && !counter_a_irq_enable) |=> counter_a_pending_flag ##1 !o_irq_request || counter_a_irq_enable || (|(armed_sources & 8'hbf)) || !global_irq_enable || $past(write_enable);
  endproperty
  a_counter_a_set: assert property (p_counter_a_set)
    else $error("counter a flag or request wrong while disabled");

  property p_counter_b_set;
    i_counter_b_overflow |=> counter_b_pending_flag;
  endproperty
  a_counter_b_set: assert property (p_counter_b_set)
    else $error("counter b overflow did not set its flag");

  property p_request_has_cause;
    o_irq_request |-> $past(global_irq_enable) && ($past(armed_sources) != 8'h00);
  endproperty
  a_request_has_cause: assert property (p_request_has_cause)
    else $error("request raised without an enabled pending source");

  property p_request_follows;
    (global_irq_enable && (armed_sources != 8'h00)) |=> o_irq_request;
  endproperty
  a_request_follows: assert property (p_request_follows)
    else $error("armed source did not raise the request");

  property p_no_request_without_gie;
    !global_irq_enable |=> !o_irq_request;
  endproperty
  a_no_request_without_gie: assert property (p_no_request_without_gie)
    else $error("request raised while global enable is low");

  sequence s_accept;
    o_irq_request && i_irq_accept;
  endsequence

  sequence s_entry;
    o_vector_load && o_stack_push && (o_vector_address == `TIRQ_VECTOR_ADDR) ##1 !o_stack_push;
  endsequence

  property p_vector_entry;
    s_accept and !$past(i_irq_accept && o_irq_request) |=> s_entry;
  endproperty
  a_vector_entry: assert property (p_vector_entry)
    else $error("accepted request did not give one vector load and push");

  property p_push_needs_accept;
    o_stack_push |-> $past(i_irq_accept) && $past(o_irq_request);
  endproperty
  a_push_needs_accept: assert property (p_push_needs_accept)
    else $error("stack push without an accepted request");

  property p_set_wins;
    (i_timer_a_overflow && write_flags && !i_write_data[`TIRQ_BIT_TIMER_A]) |=> timer_a_pending_flag;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("same-cycle clear beat a new overflow");

  property p_flag_holds;
    (counter_b_pending_flag && !(write_flags && !i_write_data[`TIRQ_BIT_COUNTER_B])) |=> counter_b_pending_flag;
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("pending flag dropped without a software clear");

  property p_flag_clears;
    (write_flags && !i_write_data[`TIRQ_BIT_TIMER_B] && !i_timer_b_overflow) |=> !timer_b_pending_flag;
  endproperty
  a_flag_clears: assert property (p_flag_clears)
    else $error("software clear did not clear the flag");

  property p_reserved_edge;
    ($past(pin_edge_select[1:0]) == `TIRQ_EDGE_RSVD) |-> !pin_a_edge;
  endproperty
  a_reserved_edge: assert property (p_reserved_edge)
    else $error("pin edge reported under the reserved code");

  property p_pin_sets_flag;
    pin_b_edge |=> pin_b_pending_flag;
  endproperty
  a_pin_sets_flag: assert property (p_pin_sets_flag)
    else $error("pin edge did not set its flag");

  property p_read_one_cycle;
    (i_read_strobe && addr_is(i_address, `TIRQ_ADDR_ENABLE)) |=> (o_read_data == $past(irq_enable));
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle)
    else $error("enable register read back wrong");

endmodule : tirq_request

`default_nettype wire

// ---- sim/tirq_core_model.sv ----
/*
  Stand-in for the processor core that takes the shared vector.
  Assumes the bench arms one accept at a time, as fast or slow as it likes.
*/
`timescale 1ns/10ps
`default_nettype none

module tirq_core_model
  import tirq_pkg::*;
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  // bench control
  input  wire logic        i_arm,
  // block side
  input  wire logic        i_irq_request,
  input  wire logic        i_vector_load,
  input  wire logic        i_stack_push,
  input  wire logic [15:0] i_vector_address,
  output logic             o_irq_accept,
  // observed core state
  output logic      [15:0] o_pc,
  output logic      [3:0]  o_depth
);
  // source checks and priority are left to the bench service task
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_irq_accept <= 1'b0;
      o_pc         <= 16'h0000;
      o_depth      <= 4'h0;
    end else begin
      o_irq_accept <= i_arm & i_irq_request;
      if (i_vector_load) o_pc <= i_vector_address;
      if (i_stack_push) o_depth <= o_depth + 4'h1;
    end
  end
endmodule : tirq_core_model

`default_nettype wire

// ---- sim/tb_tirq_request.sv ----
/*
  Self-checking bench for the timer interrupt request logic.
  Assumes the core stand-in model and the design files are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tirq_consts.svh"

module tb_tirq_request
  import tirq_pkg::*;
;
  logic        i_clock;
  logic        i_reset;
  logic        ws;
  logic        rs;
  logic        pin;
  logic        arm;
  logic        acc;
  logic        vl;
  logic        sp;
  logic        req;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [3:0]  ovf;
  logic [3:0]  depth;
  logic [15:0] vaddr;
  logic [15:0] pc;
  int          bad_count;
  int          cmp_count;

  tirq_request dut (.i_clock(i_clock), .i_reset(i_reset), .i_address(addr),
    .i_write_data(wdata), .i_write_strobe(ws), .i_read_strobe(rs), .o_read_data(rdata),
    .i_timer_a_overflow(ovf[0]), .i_timer_b_overflow(ovf[1]),
    .i_counter_a_overflow(ovf[2]), .i_counter_b_overflow(ovf[3]),
    .i_pin_a(pin), .i_pin_b(pin), .i_irq_accept(acc), .o_irq_request(req),
    .o_vector_load(vl), .o_stack_push(sp), .o_vector_address(vaddr));

  tirq_core_model core (.i_clock(i_clock), .i_reset(i_reset), .i_arm(arm),
    .i_irq_request(req), .i_vector_load(vl), .i_stack_push(sp),
    .i_vector_address(vaddr), .o_irq_accept(acc), .o_pc(pc), .o_depth(depth));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    ws <= 1'b1; addr <= a; wdata <= d;
    @(posedge i_clock);
    ws <= 1'b0;
  endtask : wr

  // read data only stands in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    rs <= 1'b1; addr <= a;
    @(posedge i_clock);
    rs <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, exp});
  endtask : rd_chk

  task automatic ovf_pulse(input logic [3:0] m);
    @(posedge i_clock);
    ovf <= m;
    @(posedge i_clock);
    ovf <= 4'h0;
  endtask : ovf_pulse

  task automatic req_chk(input logic exp);
    @(posedge i_clock);
    #1 chk({15'h0, req}, {15'h0, exp});
  endtask : req_chk

  task automatic t_reset;
    rd_chk(`TIRQ_ADDR_FLAGS, 8'h00);
    rd_chk(`TIRQ_ADDR_ENABLE, 8'h00);
    rd_chk(`TIRQ_ADDR_CONTROL, 8'h00);
    rd_chk(`TIRQ_ADDR_EDGE, 8'h0a);
    wr(8'h04, 8'hff);
    rd_chk(8'h04, 8'h00);
    wr(`TIRQ_ADDR_FLAGS, 8'hff);
    rd_chk(`TIRQ_ADDR_FLAGS, 8'h00);
  endtask : t_reset

  // flags set with every enable off, no request
  task automatic t_no_enable;
    for (int i = 0; i < 4; i++) begin
      ovf_pulse(4'h1 << i);
      req_chk(1'b0);
      rd_chk(`TIRQ_ADDR_FLAGS, 8'h10 << i);
      wr(`TIRQ_ADDR_FLAGS, 8'h00);
    end
  endtask : t_no_enable

  task automatic t_gate;
    for (int i = 0; i < 4; i++) begin
      wr(`TIRQ_ADDR_ENABLE, 8'h10 << i);
      ovf_pulse(4'h1 << i);
      req_chk(1'b0);
      wr(`TIRQ_ADDR_CONTROL, 8'h80);
      req_chk(1'b1);
      wr(`TIRQ_ADDR_ENABLE, 8'h00);
      req_chk(1'b0);
      wr(`TIRQ_ADDR_CONTROL, 8'h00);
      wr(`TIRQ_ADDR_FLAGS, 8'h00);
    end
  endtask : t_gate

  // slow core: accept three cycles after the request rises
  task automatic t_entry;
    wr(`TIRQ_ADDR_ENABLE, 8'h10);
    wr(`TIRQ_ADDR_CONTROL, 8'h80);
    ovf_pulse(4'h1);
    repeat (3) @(posedge i_clock);
    arm <= 1'b1;
    @(posedge i_clock);
    arm <= 1'b0;
    // load and push stand one cycle after the accepting edge
    @(posedge i_clock);
    #1 chk({14'h0, vl, sp}, 16'h0003);
    chk(vaddr, `TIRQ_VECTOR_ADDR);
    @(posedge i_clock);
    #1 chk(pc, 16'h0008);
    chk({12'h0, depth}, 16'h0001);
    chk({14'h0, vl, sp}, 16'h0000);
    wr(`TIRQ_ADDR_CONTROL, 8'h00);
    req_chk(1'b0);
    wr(`TIRQ_ADDR_FLAGS, 8'h00);
    wr(`TIRQ_ADDR_ENABLE, 8'h00);
  endtask : t_entry

  // service code: check enable and flag, then its own order
  task automatic t_service;
    wr(`TIRQ_ADDR_ENABLE, 8'h90);
    wr(`TIRQ_ADDR_CONTROL, 8'h80);
    ovf_pulse(4'hb);
    req_chk(1'b1);
    rd_chk(`TIRQ_ADDR_FLAGS, 8'hb0);
    rd_chk(`TIRQ_ADDR_ENABLE, 8'h90);
    // counter b served first, timer b left pending as disabled
    wr(`TIRQ_ADDR_FLAGS, 8'h7f);
    req_chk(1'b1);
    wr(`TIRQ_ADDR_FLAGS, 8'hef);
    req_chk(1'b0);
    rd_chk(`TIRQ_ADDR_FLAGS, 8'h20);
    wr(`TIRQ_ADDR_CONTROL, 8'h00);
    wr(`TIRQ_ADDR_FLAGS, 8'h00);
    wr(`TIRQ_ADDR_ENABLE, 8'h00);
  endtask : t_service

  task automatic t_set_wins;
    @(posedge i_clock);
    ws <= 1'b1; addr <= `TIRQ_ADDR_FLAGS; wdata <= 8'h00; ovf <= 4'h1;
    @(posedge i_clock);
    ws <= 1'b0; ovf <= 4'h0;
    rd_chk(`TIRQ_ADDR_FLAGS, 8'h10);
    wr(`TIRQ_ADDR_FLAGS, 8'hff);
    rd_chk(`TIRQ_ADDR_FLAGS, 8'h10);
    wr(`TIRQ_ADDR_FLAGS, 8'h00);
    rd_chk(`TIRQ_ADDR_FLAGS, 8'h00);
  endtask : t_set_wins

  // every edge code on each pin, pin b given the inverse code of pin a
  task automatic t_pins;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(`TIRQ_ADDR_EDGE, {4'h0, ~c, c});
      wr(`TIRQ_ADDR_FLAGS, 8'h00);
      @(posedge i_clock);
      pin <= 1'b1;
      repeat (6) @(posedge i_clock);
      rd_chk(`TIRQ_ADDR_FLAGS, {6'h0, ~c[0], c[0]});
      wr(`TIRQ_ADDR_FLAGS, 8'h00);
      @(posedge i_clock);
      pin <= 1'b0;
      repeat (6) @(posedge i_clock);
      rd_chk(`TIRQ_ADDR_FLAGS, {6'h0, ~c[1], c[1]});
    end
    wr(`TIRQ_ADDR_FLAGS, 8'h00);
  endtask : t_pins

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  // whole run needs well under a thousand cycles
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    bad_count = 0;
    cmp_count = 0;
    i_reset = 1'b1;
    ws = 1'b0;
    rs = 1'b0;
    pin = 1'b0;
    arm = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    ovf = 4'h0;
    repeat (12) @(posedge i_clock);
    i_reset <= 1'b0;
    t_reset();
    t_no_enable();
    t_gate();
    t_entry();
    t_service();
    t_set_wins();
    t_pins();
    report_and_stop();
  end
endmodule : tb_tirq_request

`default_nettype wire
